// file: hw/drp_pkg.sv
/*
  Constants, types and command decode for the DDR2 refresh and power-down
  block, plus the state type of the self-refresh timer that runs on the device's own clock.
  Assumes a 25 MHz system clock and a command clock from the controller.
*/
// Function
// - Refresh decoded on CS RAS CAS low
// - Internal bank counter; banks idle after refresh
// - Self-refresh entry decoded with CKE low
// - Self-refresh ignores inputs, DLL off then on
// - Internal refresh within min_clock_enable_period
// - Power-down enters, exits on CKE with NOP
// - Precharge or active power-down by open rows
// - Mode bit A12 selects slow active exit
// - Power-down gates buffers, DLL off if precharged
// - NOP decoded, running operations continue
// - Deselect ignores other pins, acts as NOP
package drp_pkg;
  localparam int unsigned SYS_CLK_MHZ = 25;
  localparam int unsigned AVG_REFRESH_INTERVAL_NS = 7800;
  localparam int unsigned AVG_REFRESH_INTERVAL_CYC = AVG_REFRESH_INTERVAL_NS * SYS_CLK_MHZ / 1000;
  localparam int unsigned MIN_CLOCK_ENABLE_PERIOD_NS = 120;
  localparam int unsigned MIN_CLOCK_ENABLE_PERIOD_CYC =
    (MIN_CLOCK_ENABLE_PERIOD_NS * SYS_CLK_MHZ / 1000 < 1) ? 1 :
    MIN_CLOCK_ENABLE_PERIOD_NS * SYS_CLK_MHZ / 1000;
  localparam int unsigned NUM_BANKS = 4;
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned ADDR_ALL_BIT = 10;
  localparam int unsigned MR_PD_EXIT_BIT = 12;
  localparam logic [7:0] SR_CNT_RST = 8'h00;
  localparam logic [7:0] SR_CNT_LAST = 8'(AVG_REFRESH_INTERVAL_CYC - 1);

  typedef enum logic [1:0] {DRP_IDLE, DRP_PD_PRE, DRP_PD_ACT, DRP_SELF_REF} drp_state_t;
  typedef enum logic [2:0] {DRP_DES, DRP_NOP, DRP_ACT, DRP_PRE, DRP_REF, DRP_MRW, DRP_OTHER}
    drp_cmd_t;

  typedef struct packed {
    drp_state_t state;
    logic cke_prev;
    logic [NUM_BANKS-1:0] banks;
    logic [1:0] ref_bank;
    logic a12;
    logic refresh;
    logic sr;
    logic pdp;
    logic pda;
    logic slow;
    logic dll;
    logic buf_en;
  } drp_link_t;

  localparam drp_link_t LINK_RST = '{state: DRP_IDLE, cke_prev: 1'b0, banks: 4'h0,
    ref_bank: 2'h0, a12: 1'b0, refresh: 1'b0, sr: 1'b0, pdp: 1'b0, pda: 1'b0,
    slow: 1'b0, dll: 1'b1, buf_en: 1'b1};

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic pulse;
    logic [7:0] cnt;
    logic [7:0] nref;
  } drp_timer_t;

  localparam drp_timer_t TIMER_RST = '{sync1: 1'b0, sync2: 1'b0, pulse: 1'b0,
    cnt: SR_CNT_RST, nref: 8'h00};

  function automatic drp_cmd_t drp_decode(input logic cs_b, input logic ras_b,
                                          input logic cas_b, input logic we_b);
    drp_cmd_t c;
    c = DRP_OTHER;
    if (cs_b) c = DRP_DES;
    else case ({ras_b, cas_b, we_b})
      3'h7: c = DRP_NOP;
      3'h3: c = DRP_ACT;
      3'h2: c = DRP_PRE;
      3'h1: c = DRP_REF;
      3'h0: c = DRP_MRW;
      default: c = DRP_OTHER;
    endcase
    return c;
  endfunction
endpackage

// file: hw/drp_sr_timer.sv
/*
  Self-refresh timer on the system clock. Takes the self-refresh level from
  the command clock domain through two flip-flops and issues internal
  refresh pulses while the command clock may be stopped.
*/
`timescale 1ns/10ps
module drp_sr_timer (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_sr_level,
  output logic o_int_refresh_q,
  output logic o_sr_seen_q,
  output logic [7:0] o_int_refresh_count_q
);
  import drp_pkg::*;
  drp_timer_t q, d;

  always_comb begin
    d = q;
    d.sync1 = i_sr_level;
    d.sync2 = q.sync1;
    d.pulse = 1'b0;
    if (!q.sync2) begin
      d.cnt = SR_CNT_RST;
    end else begin
      d.pulse = (q.cnt == SR_CNT_RST);
      d.cnt = (q.cnt == SR_CNT_LAST) ? SR_CNT_RST : q.cnt + 8'h01;
      if (q.cnt == SR_CNT_RST) d.nref = q.nref + 8'h01;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) q <= TIMER_RST;
    else q <= d;
  end

  assign o_int_refresh_q = q.pulse;
  assign o_sr_seen_q = q.sync2;
  assign o_int_refresh_count_q = q.nref;

  localparam int FIRST_LO = 2;
  localparam int FIRST_HI = 3;
  localparam int GAP = 194;

  // Cycles since the last pulse, saturating; parked at all ones outside self-refresh
  logic [7:0] since_q;
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) since_q <= 8'hFF;
    else if (!q.sync2) since_q <= 8'hFF;
    else if (q.pulse) since_q <= 8'h00;
    else if (since_q != 8'hFF) since_q <= since_q + 8'h01;
  end

  a_first_int_refresh: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    $rose(q.sync1) |-> ##[FIRST_LO:FIRST_HI] o_int_refresh_q)
    else $error("no internal refresh soon after self-refresh entry");

  a_int_refresh_gap: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (o_int_refresh_q && q.sync2 && q.sync1) |-> ##195 (o_int_refresh_q || !$past(q.sync2)))
    else $error("internal refresh spacing wrong");

  a_int_refresh_min: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    o_int_refresh_q |-> (since_q == 8'hFF) || (since_q == 8'(GAP)))
    else $error("internal refresh too early");
endmodule

// file: hw/drp_refresh_pd.sv
/*
  Refresh, self-refresh and power-down state of the memory device.
  Command logic runs on the controller's clock; the self-refresh timer runs
  on the system clock and sees only a synchronised level.
*/
`timescale 1ns/10ps
module drp_refresh_pd (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_ck,
  input wire logic i_cke,
  input wire logic i_cs_b,
  input wire logic i_ras_b,
  input wire logic i_cas_b,
  input wire logic i_we_b,
  input wire logic [1:0] i_ba,
  input wire logic [drp_pkg::ADDR_W-1:0] i_addr,
  output logic o_refresh_q,
  output logic [1:0] o_refresh_bank_q,
  output logic [drp_pkg::NUM_BANKS-1:0] o_bank_open_q,
  output logic o_self_refresh_q,
  output logic o_pd_precharge_q,
  output logic o_pd_active_q,
  output logic o_pd_slow_exit_q,
  output logic o_dll_en_q,
  output logic o_in_buf_en_q,
  output logic o_int_refresh_q,
  output logic o_sr_seen_q,
  output logic [7:0] o_int_refresh_count_q
);
  import drp_pkg::*;
  drp_link_t q, d;
  drp_cmd_t cmd;
  logic idle_live;
  logic is_nop;

  assign cmd = drp_decode(i_cs_b, i_ras_b, i_cas_b, i_we_b);
  assign idle_live = (q.state == DRP_IDLE) && q.cke_prev;
  assign is_nop = (cmd == DRP_NOP) || (cmd == DRP_DES);

  always_comb begin
    d = q;
    d.cke_prev = i_cke;
    d.refresh = 1'b0;
    case (q.state)
      DRP_IDLE: begin
        if (q.cke_prev && !i_cke) begin
          if (cmd == DRP_REF) begin
            d.state = DRP_SELF_REF;
            d.banks = '0;
          end else if (is_nop) begin
            d.state = (q.banks != '0) ? DRP_PD_ACT : DRP_PD_PRE;
          end
        end else if (q.cke_prev) begin
          case (cmd)
            DRP_ACT: d.banks[i_ba] = 1'b1;
            DRP_PRE: begin
              if (i_addr[ADDR_ALL_BIT]) d.banks = '0;
              else d.banks[i_ba] = 1'b0;
            end
            DRP_REF: begin
              d.refresh = 1'b1;
              d.ref_bank = q.ref_bank + 2'h1;
              d.banks = '0;
            end
            DRP_MRW: begin
              if (i_ba == 2'h0) d.a12 = i_addr[MR_PD_EXIT_BIT];
            end
            default: d.banks = q.banks;
          endcase
        end
      end
      DRP_PD_PRE, DRP_PD_ACT: begin
        if (i_cke && is_nop) d.state = DRP_IDLE;
      end
      DRP_SELF_REF: begin
        if (i_cke) d.state = DRP_IDLE;
      end
      default: d.state = DRP_IDLE;
    endcase
    d.sr = (d.state == DRP_SELF_REF);
    d.pdp = (d.state == DRP_PD_PRE);
    d.pda = (d.state == DRP_PD_ACT);
    d.slow = (d.state == DRP_PD_ACT) && d.a12;
    d.dll = !((d.state == DRP_SELF_REF) || (d.state == DRP_PD_PRE));
    d.buf_en = (d.state == DRP_IDLE);
  end

  always_ff @(posedge i_ck or negedge i_rst_b) begin
    if (!i_rst_b) q <= LINK_RST;
    else q <= d;
  end

  drp_sr_timer u_sr_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_sr_level(q.sr),
    .o_int_refresh_q(o_int_refresh_q),
    .o_sr_seen_q(o_sr_seen_q),
    .o_int_refresh_count_q(o_int_refresh_count_q)
  );

  assign o_refresh_q = q.refresh;
  assign o_refresh_bank_q = q.ref_bank;
  assign o_bank_open_q = q.banks;
  assign o_self_refresh_q = q.sr;
  assign o_pd_precharge_q = q.pdp;
  assign o_pd_active_q = q.pda;
  assign o_pd_slow_exit_q = q.slow;
  assign o_dll_en_q = q.dll;
  assign o_in_buf_en_q = q.buf_en;

  default clocking cb @(posedge i_ck);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_ref_cmd;
    idle_live && i_cke && (cmd == DRP_REF);
  endsequence
  sequence s_sr_cmd;
    idle_live && !i_cke && (cmd == DRP_REF);
  endsequence
  sequence s_pd_cmd;
    idle_live && !i_cke && is_nop;
  endsequence
  sequence s_mrw_cmd;
    idle_live && i_cke && (cmd == DRP_MRW) && (i_ba == 2'h0);
  endsequence

  a_ref_decode: assert property (s_ref_cmd |=> o_refresh_q ##1 !o_refresh_q)
    else $error("refresh not decoded");
  a_ref_bank_step: assert property (s_ref_cmd |=>
    (o_refresh_bank_q == $past(o_refresh_bank_q) + 2'h1) && (o_bank_open_q == '0))
    else $error("refresh bank counter or idle banks wrong");
  a_sr_entry: assert property (s_sr_cmd |=> o_self_refresh_q && !o_dll_en_q)
    else $error("self-refresh entry missed");
  a_sr_exit_dll: assert property (o_self_refresh_q && i_cke |=>
    !o_self_refresh_q && o_dll_en_q && o_in_buf_en_q)
    else $error("self-refresh exit wrong");
  a_sr_ignore: assert property (o_self_refresh_q && !i_cke |=>
    o_self_refresh_q && $stable(o_bank_open_q) && !o_refresh_q)
    else $error("input acted on in self-refresh");
  a_pd_kind: assert property (s_pd_cmd |=>
    (o_pd_active_q == ($past(o_bank_open_q) != '0)) && (o_pd_active_q != o_pd_precharge_q))
    else $error("power-down kind wrong");
  a_pd_exit: assert property ((o_pd_active_q || o_pd_precharge_q) && i_cke && is_nop |=>
    !o_pd_active_q && !o_pd_precharge_q ##1 $stable(o_bank_open_q))
    else $error("power-down exit wrong");
  a_pd_slow_sel: assert property (s_mrw_cmd ##1 (s_pd_cmd and (o_bank_open_q != '0)) |=>
    o_pd_slow_exit_q == $past(i_addr[MR_PD_EXIT_BIT], 2))
    else $error("slow exit select wrong");
  a_pd_buffers: assert property (s_pd_cmd |=>
    !o_in_buf_en_q && (o_dll_en_q == ($past(o_bank_open_q) != '0)))
    else $error("power-down buffer or dll state wrong");
  a_nop_keep: assert property (idle_live && i_cke && (cmd == DRP_NOP) |=>
    $stable(o_bank_open_q) && $stable(o_refresh_bank_q) && !o_refresh_q)
    else $error("nop changed state");
  a_des_ignore: assert property (idle_live && i_cke && i_cs_b |=>
    $stable(o_bank_open_q) && !o_refresh_q && !o_self_refresh_q)
    else $error("deselect acted");
endmodule

// file: verif/drp_ctrl_model.sv
/*
  Controller model: makes the command clock and drives the command pins.
  Assumes the bench calls issue() only after reset is released.
*/
`timescale 1ns/10ps
module drp_ctrl_model (
  output logic o_ck,
  output logic o_cke,
  output logic o_cs_b,
  output logic o_ras_b,
  output logic o_cas_b,
  output logic o_we_b,
  output logic [1:0] o_ba,
  output logic [drp_pkg::ADDR_W-1:0] o_addr
);
  import drp_pkg::*;
  logic run;
  initial begin
    {o_ck, run, o_cke} = 3'h3;
    {o_cs_b, o_ras_b, o_cas_b, o_we_b} = 4'hF;
    o_ba = 2'h0;
    o_addr = '0;
    #7;
    forever begin
      #32;
      if (run) o_ck = ~o_ck;
    end
  end
  // One command, then deselect with scrambled lines
  task automatic issue(input logic k, input logic [3:0] c, input logic [1:0] b,
                       input logic [ADDR_W-1:0] a);
    @(posedge o_ck);
    o_cke <= k;
    {o_cs_b, o_ras_b, o_cas_b, o_we_b} <= c;
    o_ba <= b;
    o_addr <= a;
    @(posedge o_ck);
    o_cs_b <= 1'b1;
    {o_ras_b, o_cas_b, o_we_b} <= ~c[2:0];
    o_ba <= ~b;
    o_addr <= ~a;
    #1;
  endtask
endmodule

// file: verif/tb.sv
/*
  Bench for the refresh and power-down block.
  Assumes the controller model drives all command pins.
*/
`timescale 1ns/10ps
module tb;
  import drp_pkg::*;
  localparam logic [3:0] NOP = 4'h7;
  localparam logic [3:0] ACT = 4'h3;
  localparam logic [3:0] PRE = 4'h2;
  localparam logic [3:0] REF = 4'h1;
  localparam logic [3:0] MRW = 4'h0;
  logic i_sys_clk, i_rst_b, ck, cke, cs_b, ras_b, cas_b, we_b;
  logic [1:0] ba, rb;
  logic [ADDR_W-1:0] addr;
  logic [3:0] bo;
  logic [7:0] cnt;
  logic [6:0] st;
  logic rf, sr, pdp, pda, slow, dll, bufe, seen, ip;
  logic [7:0] ip_n = 8'h00;
  int err_total = 0;
  int cmp_count = 0;
  int tick = 0;
  assign st = {rf, sr, pdp, pda, slow, dll, bufe};
  drp_ctrl_model drp_ctrl_model_i (.o_ck(ck), .o_cke(cke), .o_cs_b(cs_b),
    .o_ras_b(ras_b), .o_cas_b(cas_b), .o_we_b(we_b), .o_ba(ba), .o_addr(addr));
  drp_refresh_pd drp_refresh_pd_i (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
    .i_ck(ck), .i_cke(cke), .i_cs_b(cs_b), .i_ras_b(ras_b), .i_cas_b(cas_b),
    .i_we_b(we_b), .i_ba(ba), .i_addr(addr), .o_refresh_q(rf),
    .o_refresh_bank_q(rb), .o_bank_open_q(bo), .o_self_refresh_q(sr),
    .o_pd_precharge_q(pdp), .o_pd_active_q(pda), .o_pd_slow_exit_q(slow),
    .o_dll_en_q(dll), .o_in_buf_en_q(bufe), .o_int_refresh_q(ip),
    .o_sr_seen_q(seen), .o_int_refresh_count_q(cnt));
  task automatic go(input logic k, input logic [3:0] c, input logic [1:0] b,
                    input logic [ADDR_W-1:0] a);
    drp_ctrl_model_i.issue(k, c, b, a);
  endtask
  task automatic chk_st(input logic [6:0] exp);
    cmp_count++;
    if (st !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, st, exp);
    end
  endtask
  task automatic chk_num(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (err_total == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    tick <= tick + 1;
    if (ip === 1'b1) ip_n <= ip_n + 8'h01;
    if (tick == 2000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    i_rst_b = 1'b0;
    repeat (5) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    #1;
    chk_st(7'h03);
    chk_num(cnt, 8'h00);
    go(1'b1, NOP, 2'h0, 14'h0000);
    go(1'b1, ACT, 2'h2, 14'h0000);
    chk_num({4'h0, bo}, 8'h04);
    go(1'b1, PRE, 2'h2, 14'h0000);
    chk_num({4'h0, bo}, 8'h00);
    go(1'b1, ACT, 2'h1, 14'h0000);
    go(1'b1, ACT, 2'h3, 14'h0000);
    go(1'b1, PRE, 2'h0, 14'h0400);
    chk_num({4'h0, bo}, 8'h00);
    for (int i = 1; i < 6; i++) begin
      go(1'b1, REF, 2'(i), 14'h3FFF);
      chk_st(7'h43);
      chk_num({6'h00, rb}, 8'(i % 4));
    end
    go(1'b1, ACT, 2'h0, 14'h0000);
    chk_st(7'h03);
    go(1'b0, NOP, 2'h0, 14'h0000);
    chk_st(7'h0A);
    go(1'b0, ACT, 2'h1, 14'h0000);
    chk_num({4'h0, bo}, 8'h01);
    go(1'b1, 4'h9, 2'h0, 14'h0000);
    chk_st(7'h03);
    go(1'b1, MRW, 2'h0, 14'h1000);
    go(1'b0, NOP, 2'h0, 14'h0000);
    chk_st(7'h0E);
    go(1'b1, NOP, 2'h0, 14'h0000);
    chk_st(7'h03);
    go(1'b1, PRE, 2'h0, 14'h0400);
    go(1'b0, 4'h8, 2'h0, 14'h0000);
    chk_st(7'h10);
    go(1'b1, NOP, 2'h0, 14'h0000);
    chk_st(7'h03);
    go(1'b0, REF, 2'h0, 14'h0000);
    chk_st(7'h20);
    @(posedge ck);
    drp_ctrl_model_i.run = 1'b0;
    repeat (MIN_CLOCK_ENABLE_PERIOD_CYC + 3) @(posedge i_sys_clk);
    #1;
    chk_num(cnt, 8'h01);
    chk_num({7'h00, seen}, 8'h01);
    repeat (AVG_REFRESH_INTERVAL_CYC) @(posedge i_sys_clk);
    #1;
    chk_num(cnt, 8'h02);
    chk_num(ip_n, 8'h02);
    drp_ctrl_model_i.run = 1'b1;
    go(1'b0, ACT, 2'h2, 14'h0000);
    chk_st(7'h20);
    chk_num({4'h0, bo}, 8'h00);
    go(1'b1, NOP, 2'h0, 14'h0000);
    chk_st(7'h03);
    go(1'b1, REF, 2'h0, 14'h0000);
    chk_st(7'h43);
    end_of_test();
  end
endmodule
